/* src/lcp_pkg.sv */
// Package with constants for the LED color loop pin control block
package lcp_pkg;
	localparam int unsigned CLK_HZ         = 50_000_000;
	localparam int unsigned DIR_HOLD_MS    = 100;
	localparam int unsigned DIR_HOLD_CYC   = (CLK_HZ / 1000) * DIR_HOLD_MS;
	localparam int unsigned STEP_MS        = 20;
	localparam int unsigned STEP_CYC       = (CLK_HZ / 1000) * STEP_MS;
	localparam int unsigned PWM_HZ         = 610;
	localparam int unsigned PWM_BITS       = 12;
	localparam int unsigned PWM_TICK_CYC   = CLK_HZ / (PWM_HZ * (1 << PWM_BITS));
	localparam logic [4:0]  ADDR_UPPER     = 5'h15;
	localparam logic [11:0] LEVEL_RST      = 12'h800;
	localparam logic [11:0] SLIDER_RST     = 12'h000;
	localparam logic [11:0] LEVEL_STEP     = 12'h010;
	localparam logic [11:0] SLIDER_STEP    = 12'h010;
	localparam logic [7:0]  ERR_RST        = 8'h00;
	localparam logic        POL_RST        = 1'b0;
	typedef enum logic [1:0] {
		LCP_IDLE = 2'b00,
		LCP_BOTH = 2'b01,
		LCP_DONE = 2'b11
	} lcp_btn_e;
endpackage : lcp_pkg

/* src/lcp_top.sv */
// Pin level control: reset, sleep, clock select, address, buttons, PWM and error flag
`timescale 1ns/10ps
// How it works
// [R1] Async active-low reset loads reset values into all state (level 0x800, address 1010100)
// [R2] Reset must be held low 10 us
// [R3] Sleep high gates core state updates
// [R4] Clock select picks internal or external clock
// [R5] Address pins give address bits one, zero
// [R6] SDA direction signal set by I2C logic
// [R7] Color button alone steps slider current direction
// [R8] Both buttons 0.1 s reverse direction
// [R9] Level button alone steps brightness by direction
// [R10] Three 12-bit PWM outputs for RGB
// [R11] Polarity bit inverts all PWM outputs
// [R12] Error flag high with readable error code
// [R13] Upper address bits fixed at 10101
// [R14] PWM period near 610 Hz
// [R15] Buttons synchronised, overlap counted before toggle
// [R16] Error flag holds until error read
module lcp_top
	import lcp_pkg::*;
#(
	parameter int unsigned DIR_HOLD = DIR_HOLD_CYC,
	parameter int unsigned STEP     = STEP_CYC
)(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire logic        sleep_in,
	input  wire logic        clk_sel,
	input  wire logic        external_clock_in,
	input  wire logic        addr_pin_hi,
	input  wire logic        addr_pin_lo,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        i2c_drive_req,
	input  wire logic        i2c_drive_val,
	input  wire logic        color_button,
	input  wire logic        level_button,
	input  wire logic        drive_polarity_bit,
	input  wire logic        polarity_wr,
	input  wire logic [11:0] duty_r,
	input  wire logic [11:0] duty_g,
	input  wire logic [11:0] duty_b,
	input  wire logic        err_set,
	input  wire logic [7:0]  err_code,
	input  wire logic        err_read,
	output logic [7:0]       err_reg_out,
	output logic             err_flag,
	output logic             pwm_r,
	output logic             pwm_g,
	output logic             pwm_b,
	output logic [6:0]       slave_addr,
	output logic             sleep_out,
	output logic             ext_clk_mode,
	output logic             core_tick,
	output logic             sda_sampled,
	output logic [11:0]      slider_out,
	output logic [11:0]      level_out,
	output logic             dir_down
);
	import lcp_pkg::*;

	logic [1:0]  sleep_sync_reg, sel_sync_reg, col_sync_reg, lev_sync_reg;
	logic [1:0]  a_hi_sync_reg, a_lo_sync_reg, sda_sync_reg;
	logic [2:0]  ext_sync_reg;
	logic        run;
	logic        ext_rise;
	logic        core_en;
	lcp_btn_e    btn_reg;
	logic [31:0] hold_cnt_reg;
	logic [31:0] step_cnt_reg;
	logic        step_ok;
	logic [11:0] slider_reg, level_reg;
	logic        dir_reg;
	logic        pol_reg;
	logic [15:0] tick_cnt_reg;
	logic [11:0] pwm_cnt_reg;
	logic [7:0]  err_reg;
	logic        flag_reg;

	// Two-stage synchronisers for pin inputs, three stages for the external clock
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sleep_sync_reg <= 2'h0;
			sel_sync_reg   <= 2'h0;
			col_sync_reg   <= 2'h0;
			lev_sync_reg   <= 2'h0;
			a_hi_sync_reg  <= 2'h0;
			a_lo_sync_reg  <= 2'h0;
			sda_sync_reg   <= 2'h3;
			ext_sync_reg   <= 3'h0;
		end
		else if (clk_en)
		begin
			sleep_sync_reg <= {sleep_sync_reg[0], sleep_in};
			sel_sync_reg   <= {sel_sync_reg[0], clk_sel};
			col_sync_reg   <= {col_sync_reg[0], color_button}; // R15
			lev_sync_reg   <= {lev_sync_reg[0], level_button}; // R15
			a_hi_sync_reg  <= {a_hi_sync_reg[0], addr_pin_hi};
			a_lo_sync_reg  <= {a_lo_sync_reg[0], addr_pin_lo};
			sda_sync_reg   <= {sda_sync_reg[0], sda_in};
			ext_sync_reg   <= {ext_sync_reg[1:0], external_clock_in};
		end
	end

	assign ext_rise = ext_sync_reg[1] & ~ext_sync_reg[2];
	assign run      = clk_en & ~sleep_sync_reg[1]; // R3
	assign core_en  = run & (sel_sync_reg[1] ? ext_rise : 1'b1); // R4

	// Mode pin outputs
	always_ff @(posedge clk or negedge rst_b) // R1
	begin
		if (!rst_b)
		begin
			sleep_out    <= 1'b0;
			ext_clk_mode <= 1'b0;
			core_tick    <= 1'b0;
		end
		else if (clk_en)
		begin
			sleep_out    <= sleep_sync_reg[1]; // R3
			ext_clk_mode <= sel_sync_reg[1]; // R4
			core_tick    <= core_en;
		end
	end

	// Slave address from fixed upper bits and address pins
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			slave_addr <= {ADDR_UPPER, 2'b00};
		else if (clk_en)
			slave_addr <= {ADDR_UPPER, a_hi_sync_reg[1], a_lo_sync_reg[1]}; // R5 R13
	end

	// SDA direction and sampled level
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sda_out     <= 1'b0;
			sda_oe      <= 1'b0;
			sda_sampled <= 1'b1;
		end
		else if (clk_en)
		begin
			sda_oe      <= i2c_drive_req & ~i2c_drive_val & ~sleep_sync_reg[1]; // R6
			sda_out     <= 1'b0;
			sda_sampled <= sda_sync_reg[1]; // R6
		end
	end

	// Button state machine: both held measures reversal time
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			btn_reg      <= LCP_IDLE;
			hold_cnt_reg <= 32'h0;
			dir_reg      <= 1'b0;
		end
		else if (core_en)
		begin
			case (btn_reg)
				LCP_IDLE:
				begin
					hold_cnt_reg <= 32'h0;
					if (col_sync_reg[1] && lev_sync_reg[1])
						btn_reg <= LCP_BOTH;
				end
				LCP_BOTH:
				begin
					if (!(col_sync_reg[1] && lev_sync_reg[1]))
						btn_reg <= LCP_IDLE;
					else if (hold_cnt_reg >= DIR_HOLD - 1) // R8 R15
					begin
						dir_reg <= ~dir_reg; // R8
						btn_reg <= LCP_DONE;
					end
					else
						hold_cnt_reg <= hold_cnt_reg + 32'h1;
				end
				LCP_DONE:
				begin
					if (!col_sync_reg[1] && !lev_sync_reg[1])
						btn_reg <= LCP_IDLE;
				end
				default: btn_reg <= LCP_IDLE;
			endcase
		end
	end

	assign step_ok = (step_cnt_reg >= STEP - 1);

	// Slider and brightness stepping
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			step_cnt_reg <= 32'h0;
			slider_reg   <= SLIDER_RST;
			level_reg    <= LEVEL_RST;
		end
		else if (core_en)
		begin
			if (col_sync_reg[1] ^ lev_sync_reg[1])
				step_cnt_reg <= step_ok ? 32'h0 : step_cnt_reg + 32'h1;
			else
				step_cnt_reg <= 32'h0;
			if (step_ok && col_sync_reg[1] && !lev_sync_reg[1]) // R7
				slider_reg <= dir_reg ? slider_reg - SLIDER_STEP : slider_reg + SLIDER_STEP; // R7 R8
			if (step_ok && lev_sync_reg[1] && !col_sync_reg[1]) // R9
			begin
				if (!dir_reg && level_reg <= 12'hFFF - LEVEL_STEP)
					level_reg <= level_reg + LEVEL_STEP; // R9
				else if (dir_reg && level_reg >= LEVEL_STEP)
					level_reg <= level_reg - LEVEL_STEP; // R9
			end
		end
	end

	// Polarity bit of the first configuration register
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pol_reg <= POL_RST;
		else if (run && polarity_wr)
			pol_reg <= drive_polarity_bit; // R11
	end

	// PWM counter and outputs
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tick_cnt_reg <= 16'h0;
			pwm_cnt_reg  <= 12'h0;
			pwm_r        <= POL_RST;
			pwm_g        <= POL_RST;
			pwm_b        <= POL_RST;
		end
		else if (core_en)
		begin
			if (tick_cnt_reg >= 16'(PWM_TICK_CYC - 1)) // R14
			begin
				tick_cnt_reg <= 16'h0;
				pwm_cnt_reg  <= pwm_cnt_reg + 12'h1; // R10
			end
			else
				tick_cnt_reg <= tick_cnt_reg + 16'h1;
			pwm_r <= (pwm_cnt_reg < duty_r) ^ pol_reg; // R10 R11
			pwm_g <= (pwm_cnt_reg < duty_g) ^ pol_reg; // R10 R11
			pwm_b <= (pwm_cnt_reg < duty_b) ^ pol_reg; // R10 R11
		end
	end

	// Error register and sticky flag
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			err_reg  <= ERR_RST;
			flag_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (err_set)
			begin
				err_reg  <= err_code; // R12
				flag_reg <= 1'b1; // R12
			end
			else if (err_read)
				flag_reg <= 1'b0; // R16
		end
	end

	// Registered error outputs
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			err_flag    <= 1'b0;
			err_reg_out <= ERR_RST;
		end
		else if (clk_en)
		begin
			err_flag    <= flag_reg; // R12 R16
			err_reg_out <= err_reg;
		end
	end

	// Registered user outputs
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			slider_out <= SLIDER_RST;
			level_out  <= LEVEL_RST;
			dir_down   <= 1'b0;
		end
		else if (clk_en)
		begin
			slider_out <= slider_reg;
			level_out  <= level_reg;
			dir_down   <= dir_reg;
		end
	end
endmodule : lcp_top

/* test/lcp_top_props.sv */
// Checker for the LED loop pin control block
`timescale 1ns/10ps
module lcp_props #(parameter int unsigned DIR_HOLD = 20, parameter int unsigned STEP = 8)(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        color_button,
	input wire logic        level_button,
	input wire logic        i2c_drive_req,
	input wire logic        i2c_drive_val,
	input wire logic        err_set,
	input wire logic        err_read,
	input wire logic        err_flag,
	input wire logic        sda_oe,
	input wire logic        sleep_out,
	input wire logic        dir_down,
	input wire logic [6:0]  slave_addr,
	input wire logic [11:0] slider_out,
	input wire logic [11:0] level_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_slide;
		$changed(slider_out) ##0 $past(color_button && !level_button, 3);
	endsequence
	a_addr_upper: assert property (slave_addr[6:2] == 5'h15) else $error("upper address bits wrong");
	a_sda_cause: assert property (sda_oe |-> $past(i2c_drive_req && !i2c_drive_val)) else $error("sda driven");
	a_err_raise: assert property (err_set |-> ##2 err_flag) else $error("error flag not raised");
	a_err_hold: assert property ($fell(err_flag) |-> $past(err_read, 2)) else $error("error flag dropped");
	a_dir_cause: assert property ($changed(dir_down) |-> $past(color_button && level_button, 3)) else $error("dir");
	a_slider_step: assert property ($changed(slider_out) |-> s_slide ##0 slider_out == ($past(dir_down) ?
		$past(slider_out) - 12'h010 : $past(slider_out) + 12'h010)) else $error("slider step wrong");
	a_level_dir: assert property ($changed(level_out) |-> $past(level_button, 3) &&
		($past(dir_down) ? level_out < $past(level_out) : level_out > $past(level_out))) else $error("level step");
	a_sleep_hold: assert property (sleep_out && $past(sleep_out) |-> $stable(level_out) && $stable(slider_out))
		else $error("core moved in sleep");
endmodule : lcp_props
bind lcp_top lcp_props #(.DIR_HOLD(DIR_HOLD), .STEP(STEP)) lcp_props_i (.clk, .rst_b, .color_button,
	.level_button, .i2c_drive_req, .i2c_drive_val, .err_set, .err_read, .err_flag, .sda_oe, .sleep_out,
	.dir_down, .slave_addr, .slider_out, .level_out);

/* test/lcp_host.sv */
// Host side of the SDA wire with its pull-up
`timescale 1ns/10ps
module lcp_host (
	input  wire logic sda_oe,
	input  wire logic host_low,
	output logic      sda_in
);
	assign sda_in = !(sda_oe || host_low);
endmodule : lcp_host

/* test/tb.sv */
// Self-checking bench for the LED loop pin control block
`timescale 1ns/10ps
module tb;
	logic clk = 0, rst_b = 0, en = 1, slp = 0, csel = 0, ext = 0, ahi = 0, alo = 0, req = 0, col = 0, lvl = 0;
	logic pol = 0, pwr = 0, eset = 0, erd = 0, hlow = 0;
	logic [11:0] dr = 12'h000;
	logic [7:0]  ec = 8'h00;
	wire logic sda_in, ef, pr, pg, so, em, dd, oe, sdo, ct, ss, pb;
	wire logic [7:0]  er;
	wire logic [6:0]  sa;
	wire logic [11:0] sl, lv;
	int fail_count = 0, tests_run = 0;
	always #10 clk = ~clk;
	initial
	begin
		#3;
		forever #80 ext = ~ext;
	end
	lcp_host lcp_host_i (.sda_oe(oe), .host_low(hlow), .sda_in(sda_in));
	lcp_top #(.DIR_HOLD(20), .STEP(8)) lcp_top_i (.clk, .rst_b, .clk_en(en), .sleep_in(slp), .clk_sel(csel),
		.external_clock_in(ext), .addr_pin_hi(ahi), .addr_pin_lo(alo), .sda_in, .sda_out(sdo), .sda_oe(oe),
		.i2c_drive_req(req), .i2c_drive_val(1'b0), .color_button(col), .level_button(lvl),
		.drive_polarity_bit(pol), .polarity_wr(pwr), .duty_r(dr), .duty_g(12'h000), .duty_b(dr),
		.err_set(eset), .err_code(ec), .err_read(erd), .err_reg_out(er), .err_flag(ef), .pwm_r(pr), .pwm_g(pg),
		.pwm_b(pb), .slave_addr(sa), .sleep_out(so), .ext_clk_mode(em), .core_tick(ct), .sda_sampled(ss),
		.slider_out(sl), .level_out(lv), .dir_down(dd));
	task check(input string n, input logic [11:0] e, input logic [11:0] s);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task t_reset;
		check("slave_addr", 12'h054, {5'h00, sa});
		check("level_out", 12'h800, lv);
		ahi = 1;
		cyc(5);
		check("slave_addr", 12'h056, {5'h00, sa});
		$display("reset test done");
	endtask : t_reset
	task t_err;
		eset = 1;
		ec = 8'h5A;
		cyc(1);
		eset = 0;
		cyc(3);
		check("err_flag", 12'h001, {11'h000, ef});
		check("err_reg_out", 12'h05A, {4'h0, er});
		cyc(10);
		erd = 1;
		cyc(1);
		erd = 0;
		cyc(3);
		check("err_flag", 12'h000, {11'h000, ef});
		eset = 1;
		erd = 1;
		ec = 8'hA5;
		cyc(1);
		eset = 0;
		erd = 0;
		cyc(3);
		check("err_flag", 12'h001, {11'h000, ef});
		check("err_reg_out", 12'h0A5, {4'h0, er});
		erd = 1;
		cyc(1);
		erd = 0;
		cyc(3);
		check("err_flag", 12'h000, {11'h000, ef});
		$display("error test done");
	endtask : t_err
	task t_sda;
		req = 1;
		cyc(2);
		check("sda_in", 12'h000, {11'h000, sda_in});
		check("sda_out", 12'h000, {11'h000, sdo});
		cyc(3);
		check("sda_sampled", 12'h000, {11'h000, ss});
		req = 0;
		cyc(2);
		check("sda_in", 12'h001, {11'h000, sda_in});
		cyc(3);
		check("sda_sampled", 12'h001, {11'h000, ss});
		$display("sda test done");
	endtask : t_sda
	task t_btn;
		col = 1;
		cyc(14);
		col = 0;
		cyc(4);
		check("slider_out", 12'h010, sl);
		col = 1;
		lvl = 1;
		cyc(26);
		col = 0;
		lvl = 0;
		cyc(4);
		check("dir_down", 12'h001, {11'h000, dd});
		lvl = 1;
		cyc(14);
		lvl = 0;
		cyc(4);
		check("level_out", 12'h7F0, lv);
		$display("button test done");
	endtask : t_btn
	task t_sleep;
		slp = 1;
		cyc(4);
		check("sleep_out", 12'h001, {11'h000, so});
		lvl = 1;
		cyc(20);
		lvl = 0;
		cyc(4);
		slp = 0;
		cyc(4);
		check("level_out", 12'h7F0, lv);
		$display("sleep test done");
	endtask : t_sleep
	task t_pwm;
		int ticks;
		ticks = 0;
		dr = 12'hFFF;
		cyc(50);
		check("pwm_r", 12'h001, {11'h000, pr});
		check("pwm_b", 12'h001, {11'h000, pb});
		check("pwm_g", 12'h000, {11'h000, pg});
		pol = 1;
		pwr = 1;
		cyc(1);
		pwr = 0;
		cyc(50);
		check("pwm_g", 12'h001, {11'h000, pg});
		check("pwm_r", 12'h000, {11'h000, pr});
		csel = 1;
		cyc(5);
		check("ext_clk_mode", 12'h001, {11'h000, em});
		repeat (80)
		begin
			@(negedge clk);
			if (ct === 1'b1)
				ticks++;
		end
		check("core_tick", 12'h00A, ticks[11:0]);
		$display("pwm and clock test done");
	endtask : t_pwm
	task conclude;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	initial
	begin
		cyc(5);
		rst_b = 1;
		cyc(1);
		t_reset;
		t_err;
		t_sda;
		t_btn;
		t_sleep;
		t_pwm;
		conclude;
	end
	initial
	begin
		#200_000;
		fail_count++;
		conclude;
	end
endmodule : tb
